/* logic/ebw_cmd_map.vh */
`ifndef EBW_CMD_MAP_VH
`define EBW_CMD_MAP_VH
// Command codes
`define EBW_CMD_OTP_MODE   8'h39
`define EBW_CMD_RSVD_A     8'h3a
`define EBW_CMD_RSVD_B     8'h3b
`define EBW_CMD_BORDER     8'h3c
`define EBW_CMD_READ_SEL   8'h41
`define EBW_CMD_X_WINDOW   8'h44
// Reset values and OTP internal voltage code
`define EBW_OTP_RESET      2'h0
`define EBW_OTP_INTERNAL   2'h3
`define EBW_BORDER_RESET   8'hc0
`define EBW_XSTART_RESET   10'h000
`define EBW_XEND_RESET     10'h3bf
// Border field positions
`define EBW_BRD_SRC_HI     7
`define EBW_BRD_SRC_LO     6
`define EBW_BRD_LVL_HI     5
`define EBW_BRD_LVL_LO     4
`define EBW_BRD_LUT_HI     1
`define EBW_BRD_LUT_LO     0
// Border source encodings
`define EBW_SRC_GRAY       2'h0
`define EBW_SRC_FIXED      2'h1
`define EBW_SRC_COMMON     2'h2
`define EBW_SRC_HIZ        2'h3
`endif

/* logic/ebw_border_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "ebw_cmd_map.vh"
module ebw_border_decode (
    // Border parameter
    input  wire [7:0] borderCfg,
    // Decoded drive controls
    output reg        borderHiz,
    output reg        borderCommon,
    output reg        borderFixed,
    output reg        borderGray,
    output wire [1:0] fixedLevel,
    output wire [1:0] grayLut
);
    // (R06) Fixed level field
    assign fixedLevel = borderCfg[`EBW_BRD_LVL_HI:`EBW_BRD_LVL_LO];
    // (R07) Gray table field
    assign grayLut = borderCfg[`EBW_BRD_LUT_HI:`EBW_BRD_LUT_LO];

    // (R05) Source select decode
    always @* begin
        borderHiz    = 1'b0;
        borderCommon = 1'b0;
        borderFixed  = 1'b0;
        borderGray   = 1'b0;
        case (borderCfg[`EBW_BRD_SRC_HI:`EBW_BRD_SRC_LO])
            `EBW_SRC_GRAY:   borderGray   = 1'b1;
            `EBW_SRC_FIXED:  borderFixed  = 1'b1;
            `EBW_SRC_COMMON: borderCommon = 1'b1;
            default:         borderHiz    = 1'b1;
        endcase
    end
endmodule
`default_nettype wire

/* logic/ebw_cmd_decoder.v */
// Operation
// (R01) 39h takes two bits; 00 normal at reset, 11 internal programming voltage
// (R02) Host follows the one-time programming sequence exactly
// (R03) 3Ah and 3Bh accepted, change nothing
// (R04) 3Ch loads border byte, resets to C0h (high impedance)
// (R05) Bits 7:6 pick gray, fixed, common electrode or high impedance
// (R06) Bits 5:4 pick ground, high one, low, high two
// (R07) Bits 1:0 pick lookup table 0 to 3
// (R08) 41h stores read-back plane select, reset 0
// (R09) 44h bytes one and two form start address, low first
// (R10) Bytes three and four form end address, reset 3BFh
// (R11) Start and end bound the X window
// (R12) Command byte with select low, parameters with select high
`timescale 1ns/1ps
`default_nettype none
`include "ebw_cmd_map.vh"
module ebw_cmd_decoder (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    // Byte stream from serial front end
    input  wire       byteValid,
    input  wire       byteIsData,
    input  wire [7:0] byteIn,
    // OTP mode
    output reg  [1:0] otpMode_q,
    output wire       otpInternalVpp,
    // Border drive
    output reg  [7:0] borderCfg_q,
    output wire       borderHiz,
    output wire       borderCommon,
    output wire       borderFixed,
    output wire       borderGray,
    output wire [1:0] fixedLevel,
    output wire [1:0] grayLut,
    // Read-back plane
    output reg        readPlaneSel_q,
    // X window
    output reg  [9:0] xWindowStart_q,
    output reg  [9:0] xWindowEnd_q,
    input  wire [9:0] xAddr,
    output wire       xInWindow,
    // Status
    output reg  [7:0] activeCmd_q
);
    reg [2:0] paramIdx_q;
    reg [7:0] startLow_q;
    reg [7:0] endLow_q;

    assign otpInternalVpp = (otpMode_q == `EBW_OTP_INTERNAL);
    // (R11) Window bounds check
    assign xInWindow = (xAddr >= xWindowStart_q) && (xAddr <= xWindowEnd_q);

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            otpMode_q      <= `EBW_OTP_RESET;
            borderCfg_q    <= `EBW_BORDER_RESET;
            readPlaneSel_q <= 1'b0;
            xWindowStart_q <= `EBW_XSTART_RESET;
            xWindowEnd_q   <= `EBW_XEND_RESET;
            activeCmd_q    <= 8'h00;
            paramIdx_q     <= 3'h0;
            startLow_q     <= 8'h00;
            endLow_q       <= 8'h00;
        end else if (byteValid) begin
            // (R12) Command byte restarts sequence
            if (!byteIsData) begin
                activeCmd_q <= byteIn;
                paramIdx_q  <= 3'h0;
            end else begin
                // Saturate so surplus bytes are ignored
                if (paramIdx_q != 3'h7) begin
                    paramIdx_q <= paramIdx_q + 3'h1;
                end
                case (activeCmd_q)
                    // (R01) OTP mode write
                    `EBW_CMD_OTP_MODE: begin
                        if (paramIdx_q == 3'h0) begin
                            otpMode_q <= byteIn[1:0];
                        end
                    end
                    // (R04) Border byte load
                    `EBW_CMD_BORDER: begin
                        if (paramIdx_q == 3'h0) begin
                            borderCfg_q <= byteIn;
                        end
                    end
                    // (R08) Plane select load
                    `EBW_CMD_READ_SEL: begin
                        if (paramIdx_q == 3'h0) begin
                            readPlaneSel_q <= byteIn[0];
                        end
                    end
                    `EBW_CMD_X_WINDOW: begin
                        case (paramIdx_q)
                            3'h0: startLow_q <= byteIn;
                            // (R09) Start address commit
                            3'h1: xWindowStart_q <= {byteIn[1:0], startLow_q};
                            3'h2: endLow_q <= byteIn;
                            // (R10) End address commit
                            3'h3: xWindowEnd_q <= {byteIn[1:0], endLow_q};
                            default: ;
                        endcase
                    end
                    // (R03) Reserved codes ignored
                    default: ;
                endcase
            end
        end
    end

    ebw_border_decode u_border (
        .borderCfg    (borderCfg_q),
        .borderHiz    (borderHiz),
        .borderCommon (borderCommon),
        .borderFixed  (borderFixed),
        .borderGray   (borderGray),
        .fixedLevel   (fixedLevel),
        .grayLut      (grayLut)
    );
endmodule
`default_nettype wire

/* tb/ebw_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ebw_host_model(input wire logic core_clk,output logic byteValid,byteIsData,output logic [7:0] byteIn);
initial {byteValid,byteIsData,byteIn}=0;
// bytes in order, select low on command
task send(input logic d,input logic [7:0] b);
@(negedge core_clk) {byteValid,byteIsData,byteIn}={1'b1,d,b};
endtask
task idle;
@(negedge core_clk) {byteValid,byteIn}={1'b0,~byteIn};
endtask
endmodule
`default_nettype wire

/* tb/ebw_cmd_decoder_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ebw_cmd_decoder_sva(input wire logic core_clk,rst_n,byteValid,byteIsData,otpInternalVpp,borderHiz,borderGray,
readPlaneSel_q,xInWindow,input wire logic [7:0] byteIn,borderCfg_q,input wire logic [1:0] otpMode_q,fixedLevel,grayLut,
input wire logic [9:0] xWindowStart_q,xWindowEnd_q,xAddr);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
sequence cmdS(c); byteValid&&!byteIsData&&byteIn==c; endsequence
sequence datS; byteValid&&byteIsData; endsequence
sequence rsvdS; byteValid&&!byteIsData&&(byteIn==8'h3a||byteIn==8'h3b); endsequence
AST_OTP_VPP: assert property (otpInternalVpp==(otpMode_q==2'h3)) else $error("vpp");
AST_OTP_LOAD: assert property (cmdS(8'h39) ##1 datS |=> otpMode_q==$past(byteIn[1:0])) else $error("otp");
AST_RSVD: assert property (rsvdS ##1 datS |=> $stable(borderCfg_q)&&$stable(otpMode_q)&&$stable(readPlaneSel_q))
else $error("rsvd");
AST_BRD_LOAD: assert property (cmdS(8'h3c) ##1 datS |=> borderCfg_q==$past(byteIn)) else $error("brd");
AST_BRD_SRC: assert property (borderHiz==(borderCfg_q[7:6]==2'h3)&&borderGray==(borderCfg_q[7:6]==2'h0))
else $error("src");
AST_BRD_FLD: assert property ({fixedLevel,grayLut}=={borderCfg_q[5:4],borderCfg_q[1:0]}) else $error("fld");
AST_PLANE: assert property (cmdS(8'h41) ##1 datS |=> readPlaneSel_q==$past(byteIn[0])) else $error("pln");
AST_XSTART: assert property (cmdS(8'h44) ##1 datS[*2] |=> xWindowStart_q=={$past(byteIn[1:0]),$past(byteIn,2)})
else $error("xs");
AST_XEND: assert property (cmdS(8'h44) ##1 datS[*4] |=> xWindowEnd_q=={$past(byteIn[1:0]),$past(byteIn,2)})
else $error("xe");
AST_XWIN: assert property (xInWindow==(xWindowStart_q<=xAddr&&xAddr<=xWindowEnd_q)) else $error("xw");
endmodule
bind ebw_cmd_decoder ebw_cmd_decoder_sva u_sva(.*);
`default_nettype wire

/* tb/epd_border_otp_window_cmds_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module epd_border_otp_window_cmds_tb;
logic core_clk=0,rst_n=0,otpInternalVpp,borderHiz,borderCommon,borderFixed,borderGray,readPlaneSel_q,xInWindow;
logic byteValid,byteIsData;
logic [7:0] byteIn,borderCfg_q,activeCmd_q;
logic [1:0] otpMode_q,fixedLevel,grayLut;
logic [9:0] xWindowStart_q,xWindowEnd_q,xAddr=0;
int n_mismatch=0,tests_run=0;
ebw_cmd_decoder u_ebw_cmd_decoder(.*);
ebw_host_model u_ebw_host_model(.core_clk,.byteValid,.byteIsData,.byteIn);
initial forever #20 core_clk=~core_clk;
task chk(input logic [31:0] s,e);
tests_run++;
if (s!==e) begin
n_mismatch++;
$display("[FAIL] t=%0t seen=%h exp=%h",$time,s,e);
end
endtask
task test_done;
$display("mismatches=%0d checks=%0d",n_mismatch,tests_run);
if (n_mismatch==0&&tests_run>0) $display("Result: passed");
else $display("Result: failed");
$finish;
endtask
task wr(input logic [7:0] c,p);
u_ebw_host_model.send(0,c);
u_ebw_host_model.send(1,p);
u_ebw_host_model.idle;
endtask
task t_otp_plane;
wr(8'h39,8'h03); chk(otpInternalVpp,1);
wr(8'h3a,8'hff); wr(8'h3b,8'h00); chk({otpMode_q,borderCfg_q},{2'h3,8'hc0});
wr(8'h39,8'h00); chk(otpMode_q,0);
wr(8'h41,8'h01); chk(readPlaneSel_q,1);
wr(8'h41,8'hfe); chk(readPlaneSel_q,0);
$display("otp and plane done");
endtask
task t_border;
for (int i=0;i<4;i++) begin
wr(8'h3c,{i[1:0],i[1:0],2'h0,~i[1:0]});
chk({borderGray,borderFixed,borderCommon,borderHiz},4'h8>>i);
chk({fixedLevel,grayLut},{i[1:0],~i[1:0]});
end
$display("border done");
endtask
task t_xwin;
u_ebw_host_model.send(0,8'h44);
u_ebw_host_model.send(1,8'h10); u_ebw_host_model.send(1,8'h01);
u_ebw_host_model.send(1,8'h20); u_ebw_host_model.send(1,8'h03);
u_ebw_host_model.idle;
chk({xWindowStart_q,xWindowEnd_q},{10'h110,10'h320});
chk(activeCmd_q,8'h44);
@(negedge core_clk) xAddr=10'h10f;
#1 chk(xInWindow,0);
@(negedge core_clk) xAddr=10'h110;
#1 chk(xInWindow,1);
@(negedge core_clk) xAddr=10'h320;
#1 chk(xInWindow,1);
@(negedge core_clk) xAddr=10'h321;
#1 chk(xInWindow,0);
$display("x window done");
endtask
initial begin
#20us;
n_mismatch++;
test_done;
end
initial begin
repeat(12) @(negedge core_clk);
chk({otpMode_q,borderCfg_q,readPlaneSel_q,xWindowStart_q,xWindowEnd_q},{2'h0,8'hc0,1'b0,10'h000,10'h3bf});
rst_n=1;
t_otp_plane;
t_border;
t_xwin;
test_done;
end
endmodule
`default_nettype wire
